// ===== fpd_cfg.svh
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH

// Register offsets
`define FPD_ADDR_FAN1_DUTY   8'h30
`define FPD_ADDR_FAN2_DUTY   8'h31
`define FPD_ADDR_FAN3_DUTY   8'h32
`define FPD_ADDR_MAKER_ID    8'h3E
`define FPD_ADDR_REVISION    8'h3F
`define FPD_ADDR_CTRL        8'h40

// Control register fields
`define FPD_CTRL_START_BIT   0
`define FPD_CTRL_LOCK_BIT    1
`define FPD_CTRL_READY_BIT   2
`define FPD_CTRL_FORCE_BIT   3

// Reset values and duty codes
`define FPD_DUTY_FULL        8'hFF
`define FPD_DUTY_ZERO        8'h00
`define FPD_CTRL_RESET       8'h00
`define FPD_READ_IDLE        8'h00

// Identification values, arbitrary and neutral
`define FPD_MAKER_ID         8'hA5
`define FPD_BASE_NUMBER      4'h3
`define FPD_STEPPING         4'h9

// Power-up settle time
`define FPD_CLK_PERIOD_NS    8
`define FPD_POWERUP_NS       1000
`define FPD_POWERUP_CYCLES   ((`FPD_POWERUP_NS + `FPD_CLK_PERIOD_NS - 1) / `FPD_CLK_PERIOD_NS)
`define FPD_CNT_W            8

`endif

// ===== fpd_host.sv
`timescale 1ns/1ps
// Host side of the register strobe port
module fpd_host
  import fpd_pkg::*;
(
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // One byte written; limits come before start by caller order
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  // One byte read, taken a cycle after the strobe
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
  // Two reads back to back, strobe held high across both
  task automatic get2(input logic [7:0] a, input logic [7:0] b,
                      output logic [7:0] da, output logic [7:0] db);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    addr <= b;
    #1;
    da = rdata;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~b;
    #1;
    db = rdata;
  endtask
endmodule // fpd_host

// ===== fpd_pkg.sv
`include "fpd_cfg.svh"

package fpd_pkg;

  // Power-up sequence, Gray coded
  typedef enum logic [1:0] {
    FPD_ST_POWERUP = 2'b00,
    FPD_ST_WAITCNV = 2'b01,
    FPD_ST_READY   = 2'b11
  } fpd_phase_t;

  // Whole state of the register slice
  typedef struct packed {
    fpd_phase_t                 phase;
    logic [`FPD_CNT_W-1:0]      cnt;
    logic [2:0][7:0]            duty;
    logic [2:0][7:0]            pwm;
    logic                       start;
    logic                       lock;
    logic                       ready;
    logic                       force_full;
    logic [7:0]                 rdata;
  } fpd_state_t;

endpackage

// ===== fpd_regs.sv
// Functional notes
// RQ1 - Duty registers report present duty; reset value is all ones.
// RQ2 - With start set, duty registers and outputs follow the auto algorithm.
// RQ3 - Duty writes ignored unless that fan is manual; then byte sets duty.
// RQ4 - Duty byte is linear, value over 255, FF means full duty.
// RQ5 - Read-only eight-bit maker identification register with a fixed code.
// RQ6 - Revision: stepping low nibble, base number high nibble, bit 3 superset.
// RQ7 - Writes to identification registers change nothing.
// RQ8 - Writing start one selects programmed limits and parameters.
// RQ9 - Start zero selects built-in defaults, ignoring programmed registers.
// RQ10 - Toggling start leaves limit and parameter storage untouched.
// RQ11 - Start stays writable whatever the lock bit holds.
// RQ12 - Lock one makes limit registers read-only until power removal.
// RQ13 - Once set, lock cannot be cleared by software.
// RQ14 - Ready sets itself after power-up sequence and converters are good.
// RQ15 - Override one drives every output at full duty, lock or not.
// RQ16 - Override beats an output's disabled mode.
// RQ17 - Software should program limits before setting start.
// RQ18 - During spin-up a fan's duty reads as zero.
// RQ19 - Control: start 0, lock 1, ready 2, override 3; upper bits zero.
`timescale 1ns/1ps
`include "fpd_cfg.svh"

module fpd_regs
  import fpd_pkg::*;
(
  input  wire logic            CLK,
  input  wire logic            SRST,
  input  wire logic [7:0]      REG_ADDR,
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  input  wire logic [7:0]      REG_WDATA,
  output logic      [7:0]      REG_RDATA,
  input  wire logic [2:0][7:0] AUTO_DUTY,
  input  wire logic [2:0]      MANUAL_MODE,
  input  wire logic [2:0]      DISABLED_MODE,
  input  wire logic [2:0]      SPINUP,
  input  wire logic            CONV_OK,
  output logic      [2:0][7:0] PWM_DUTY,
  output logic                 USE_PROGRAMMED,
  output logic                 LIMITS_LOCKED,
  output logic                 FORCE_FULL_DUTY,
  output logic                 DEVICE_READY
);

  localparam logic [`FPD_CNT_W-1:0] POWERUP_LAST = `FPD_CNT_W'(`FPD_POWERUP_CYCLES - 1);
  localparam logic [7:0] MAKER_ID = `FPD_MAKER_ID;
  localparam logic [7:0] REVISION = {`FPD_BASE_NUMBER, `FPD_STEPPING};

  fpd_state_t st_reg;
  fpd_state_t st_next;
  logic [2:0] duty_hit;
  logic       ctrl_hit;

  // Address decode, one comparator per duty register; the three sit at consecutive offsets
  for (genvar g = 0; g < 3; g++) begin : g_duty_hit
    assign duty_hit[g] = (REG_ADDR == 8'(`FPD_ADDR_FAN1_DUTY + g));
  end

  // Control register decode
  assign ctrl_hit = (REG_ADDR == `FPD_ADDR_CTRL);

  // Next-state logic for the whole slice
  always_comb begin
    st_next = st_reg;

    // Power-up sequence leading to ready
    case (st_reg.phase)
      FPD_ST_POWERUP: begin
        st_next.cnt = st_reg.cnt + `FPD_CNT_W'(1);
        if (st_reg.cnt == POWERUP_LAST) begin
          st_next.phase = FPD_ST_WAITCNV;
        end
      end
      FPD_ST_WAITCNV: begin
        if (CONV_OK) begin
          st_next.phase = FPD_ST_READY;
          st_next.ready = 1'b1; // [RQ14]
        end
      end
      FPD_ST_READY: begin
        st_next.ready = 1'b1;
      end
      default: begin
        st_next.phase = FPD_ST_POWERUP;
      end
    endcase

    // Per-fan duty update: manual write, else auto algorithm once started
    for (int i = 0; i < 3; i++) begin
      if (MANUAL_MODE[i]) begin
        if (REG_WR && duty_hit[i]) begin
          st_next.duty[i] = REG_WDATA; // [RQ3]
        end
      end else if (st_reg.start) begin
        st_next.duty[i] = AUTO_DUTY[i]; // [RQ2]
      end
      // Override first, then disabled, then stored duty code
      if (st_reg.force_full) begin
        st_next.pwm[i] = `FPD_DUTY_FULL; // [RQ15] [RQ16]
      end else if (DISABLED_MODE[i]) begin
        st_next.pwm[i] = `FPD_DUTY_ZERO;
      end else begin
        st_next.pwm[i] = st_next.duty[i]; // [RQ4]
      end
    end

    // Control register write; ready and upper bits are not writable
    // Lock only ever ORs in a one, so software can never clear it
    if (REG_WR && ctrl_hit) begin
      st_next.start      = REG_WDATA[`FPD_CTRL_START_BIT]; // [RQ11] [RQ8] [RQ9]
      st_next.lock       = st_reg.lock | REG_WDATA[`FPD_CTRL_LOCK_BIT]; // [RQ12] [RQ13]
      st_next.force_full = REG_WDATA[`FPD_CTRL_FORCE_BIT];
    end

    // Read data, captured one cycle after the read strobe
    // Spin-up masks the reported duty only; the driven output is untouched
    if (REG_RD) begin
      st_next.rdata = `FPD_READ_IDLE;
      case (REG_ADDR)
        `FPD_ADDR_FAN1_DUTY: st_next.rdata = SPINUP[0] ? `FPD_DUTY_ZERO : st_reg.duty[0]; // [RQ18]
        `FPD_ADDR_FAN2_DUTY: st_next.rdata = SPINUP[1] ? `FPD_DUTY_ZERO : st_reg.duty[1]; // [RQ18]
        `FPD_ADDR_FAN3_DUTY: st_next.rdata = SPINUP[2] ? `FPD_DUTY_ZERO : st_reg.duty[2]; // [RQ1]
        `FPD_ADDR_MAKER_ID:  st_next.rdata = MAKER_ID; // [RQ5] [RQ7]
        `FPD_ADDR_REVISION:  st_next.rdata = REVISION; // [RQ6] [RQ7]
        `FPD_ADDR_CTRL: begin
          st_next.rdata = {4'h0, st_reg.force_full, st_reg.ready,
                           st_reg.lock, st_reg.start}; // [RQ19]
        end
        default: st_next.rdata = `FPD_READ_IDLE;
      endcase
    end
  end

  // State register; reset values match a cold power-up
  // with full duty on every output and every control bit clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg.phase      <= FPD_ST_POWERUP;
      st_reg.cnt        <= '0;
      st_reg.duty       <= {3{`FPD_DUTY_FULL}}; // [RQ1]
      st_reg.pwm        <= {3{`FPD_DUTY_FULL}};
      st_reg.start      <= 1'b0;
      st_reg.lock       <= 1'b0;
      st_reg.ready      <= 1'b0;
      st_reg.force_full <= 1'b0;
      st_reg.rdata      <= `FPD_READ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flops
  assign REG_RDATA       = st_reg.rdata;
  assign PWM_DUTY        = st_reg.pwm;
  assign USE_PROGRAMMED  = st_reg.start; // [RQ8] [RQ9] [RQ10]
  assign LIMITS_LOCKED   = st_reg.lock; // [RQ12]
  assign FORCE_FULL_DUTY = st_reg.force_full;
  assign DEVICE_READY    = st_reg.ready;

  // Checks on the slice
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  duty_reset_a: assert property ( // [RQ1]
    $past(SRST) |-> (st_reg.duty == {3{`FPD_DUTY_FULL}} && PWM_DUTY == {3{`FPD_DUTY_FULL}}))
    else $error("duty not full after reset");

  manual_write_a: assert property ( // [RQ3]
    REG_WR && duty_hit[0] && MANUAL_MODE[0] |=> st_reg.duty[0] == $past(REG_WDATA))
    else $error("manual duty write lost");

  write_ignored_a: assert property ( // [RQ3]
    REG_WR && duty_hit[1] && !MANUAL_MODE[1] && !st_reg.start |=> $stable(st_reg.duty[1]))
    else $error("duty write not ignored");

  auto_follow_a: assert property ( // [RQ2]
    st_reg.start && !MANUAL_MODE[2] && !st_reg.force_full && !DISABLED_MODE[2]
      |=> PWM_DUTY[2] == $past(AUTO_DUTY[2]))
    else $error("output not following auto duty");

  ident_read_a: assert property ( // [RQ5]
    REG_RD && REG_ADDR == `FPD_ADDR_MAKER_ID ##1 REG_RD && REG_ADDR == `FPD_ADDR_REVISION
      |=> REG_RDATA == REVISION && $past(REG_RDATA) == MAKER_ID)
    else $error("identification read wrong");

  lock_sticky_a: assert property ( // [RQ13]
    LIMITS_LOCKED |=> LIMITS_LOCKED [*4])
    else $error("lock cleared");

  start_free_a: assert property ( // [RQ11]
    LIMITS_LOCKED && REG_WR && ctrl_hit |=> USE_PROGRAMMED == $past(REG_WDATA[0]))
    else $error("start blocked by lock");

  override_pwm_a: assert property ( // [RQ15]
    FORCE_FULL_DUTY |=> PWM_DUTY == {3{`FPD_DUTY_FULL}})
    else $error("override not full duty");

  spinup_read_a: assert property ( // [RQ18]
    REG_RD && duty_hit[0] && SPINUP[0] |=> REG_RDATA == `FPD_DUTY_ZERO)
    else $error("spin-up duty not zero");

  ready_wait_a: assert property ( // [RQ14]
    $past(SRST) |-> !DEVICE_READY [*8])
    else $error("ready too early");

  ctrl_layout_a: assert property ( // [RQ19]
    REG_RD && ctrl_hit |=> REG_RDATA[7:4] == 4'h0
      && REG_RDATA[2] == $past(DEVICE_READY))
    else $error("control read layout wrong");

  // Power-up and ready checks
  power_span_a: assert property ( // [RQ14]
    st_reg.phase != FPD_ST_POWERUP
      |-> st_reg.cnt == POWERUP_LAST + 8'h01)
    else $error("power-up span cut short");

  ready_source_a: assert property ( // [RQ14]
    $rose(DEVICE_READY)
      |-> $past(CONV_OK) && $past(st_reg.phase) == FPD_ST_WAITCNV)
    else $error("ready rose without converters good");

  ready_sticky_a: assert property ( // [RQ14]
    DEVICE_READY
      |=> DEVICE_READY)
    else $error("ready dropped");

  // Control register checks
  ctrl_reset_a: assert property ( // [RQ19]
    $past(SRST) |-> !USE_PROGRAMMED && !LIMITS_LOCKED && !FORCE_FULL_DUTY
      && !DEVICE_READY && REG_RDATA == `FPD_READ_IDLE)
    else $error("control bits not clear after reset");

  start_write_a: assert property ( // [RQ8]
    REG_WR && ctrl_hit
      |=> USE_PROGRAMMED == $past(REG_WDATA[`FPD_CTRL_START_BIT]))
    else $error("start write lost");

  start_keep_a: assert property ( // [RQ9]
    !(REG_WR && ctrl_hit)
      |=> $stable(USE_PROGRAMMED))
    else $error("start changed without a write");

  lock_set_a: assert property ( // [RQ12]
    REG_WR && ctrl_hit && REG_WDATA[`FPD_CTRL_LOCK_BIT]
      |=> LIMITS_LOCKED)
    else $error("lock write lost");

  lock_hold_a: assert property ( // [RQ13]
    LIMITS_LOCKED && REG_WR && ctrl_hit && !REG_WDATA[`FPD_CTRL_LOCK_BIT]
      |=> LIMITS_LOCKED)
    else $error("lock cleared by a write");

  force_write_a: assert property ( // [RQ15]
    REG_WR && ctrl_hit
      |=> FORCE_FULL_DUTY == $past(REG_WDATA[`FPD_CTRL_FORCE_BIT]))
    else $error("override write lost");

  ctrl_word_a: assert property ( // [RQ19]
    REG_RD && ctrl_hit |=> REG_RDATA == {4'h0, $past(FORCE_FULL_DUTY),
      $past(DEVICE_READY), $past(LIMITS_LOCKED), $past(USE_PROGRAMMED)})
    else $error("control read word wrong");

  // Duty and output checks
  idle_hold_a: assert property ( // [RQ2]
    !st_reg.start && !MANUAL_MODE[2]
      |=> $stable(st_reg.duty[2]))
    else $error("duty moved before start");

  auto_duty_a: assert property ( // [RQ2]
    st_reg.start && !MANUAL_MODE[1]
      |=> st_reg.duty[1] == $past(AUTO_DUTY[1]))
    else $error("duty register not following auto duty");

  manual_pwm_a: assert property ( // [RQ4]
    REG_WR && duty_hit[0] && MANUAL_MODE[0] && !FORCE_FULL_DUTY && !DISABLED_MODE[0]
      |=> PWM_DUTY[0] == $past(REG_WDATA))
    else $error("manual byte not driven as duty");

  force_disabled_a: assert property ( // [RQ16]
    FORCE_FULL_DUTY && DISABLED_MODE[2]
      |=> PWM_DUTY[2] == `FPD_DUTY_FULL)
    else $error("disabled output not forced full");

  disabled_zero_a: assert property ( // [RQ16]
    !FORCE_FULL_DUTY && DISABLED_MODE[2]
      |=> PWM_DUTY[2] == `FPD_DUTY_ZERO)
    else $error("disabled output not zero");

  duty_read_a: assert property ( // [RQ1]
    REG_RD && duty_hit[1] && !SPINUP[1]
      |=> REG_RDATA == $past(st_reg.duty[1]))
    else $error("duty read not present duty");

  // Identification checks
  maker_read_a: assert property ( // [RQ5]
    REG_RD && REG_ADDR == `FPD_ADDR_MAKER_ID
      |=> REG_RDATA == MAKER_ID)
    else $error("maker code read wrong");

  rev_read_a: assert property ( // [RQ6]
    REG_RD && REG_ADDR == `FPD_ADDR_REVISION
      |=> REG_RDATA == REVISION)
    else $error("revision read wrong");

  rev_super_a: assert property ( // [RQ6]
    REG_RD && REG_ADDR == `FPD_ADDR_REVISION
      |=> REG_RDATA[3] == 1'b1)
    else $error("superset flag not set");

endmodule // fpd_regs

// ===== tb.sv
`timescale 1ns/1ps
`include "fpd_cfg.svh"
module tb
  import fpd_pkg::*;
;
  localparam logic [7:0] a1 = `FPD_ADDR_FAN1_DUTY;
  localparam logic [7:0] a2 = `FPD_ADDR_FAN2_DUTY;
  localparam logic [7:0] a3 = `FPD_ADDR_FAN3_DUTY;
  localparam logic [7:0] ct = `FPD_ADDR_CTRL;
  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic [7:0]      addr, wdata, rdata;
  logic            wr, rd, upr, lck, frc, rdy;
  logic [2:0][7:0] auto = {8'hC3, 8'h40, 8'h11};
  logic [2:0]      man = 3'b000;
  logic [2:0]      dis = 3'b000;
  logic [2:0]      spin = 3'b000;
  logic            cok = 1'b0;
  logic [2:0][7:0] pwm;
  int              err_total = 0;
  int              n_tests = 0;
  // Clock
  always #4 clk = ~clk;
  fpd_regs u_fpd_regs (.CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .AUTO_DUTY(auto),
    .MANUAL_MODE(man), .DISABLED_MODE(dis), .SPINUP(spin), .CONV_OK(cok),
    .PWM_DUTY(pwm), .USE_PROGRAMMED(upr), .LIMITS_LOCKED(lck),
    .FORCE_FULL_DUTY(frc), .DEVICE_READY(rdy));
  fpd_host u_fpd_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata(rdata));
  // Compare helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_fpd_host.get(a, d);
    chk(nm, e, d);
  endtask
  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    u_fpd_host.put(a, d);
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset values, auto duty ignored before start
  task automatic t_reset();
    rc("duty1", a1, `FPD_DUTY_FULL);
    rc("duty2", a2, `FPD_DUTY_FULL);
    rc("duty3", a3, `FPD_DUTY_FULL);
    rc("ctrl", ct, `FPD_CTRL_RESET);
    chk("pwm1", `FPD_DUTY_FULL, pwm[1]);
  endtask
  // Identification registers ignore writes
  task automatic t_ident();
    logic [7:0] d0;
    logic [7:0] d1;
    rc("id", `FPD_ADDR_MAKER_ID, `FPD_MAKER_ID);
    rc("rev", `FPD_ADDR_REVISION, {`FPD_BASE_NUMBER, `FPD_STEPPING});
    wc(`FPD_ADDR_MAKER_ID, 8'h00);
    wc(`FPD_ADDR_REVISION, 8'h00);
    rc("id", `FPD_ADDR_MAKER_ID, `FPD_MAKER_ID);
    rc("rev", `FPD_ADDR_REVISION, {`FPD_BASE_NUMBER, `FPD_STEPPING});
    u_fpd_host.get2(`FPD_ADDR_MAKER_ID, `FPD_ADDR_REVISION, d0, d1);
    chk("id_b2b", `FPD_MAKER_ID, d0);
    chk("rev_b2b", {`FPD_BASE_NUMBER, `FPD_STEPPING}, d1);
    chk("superset", 8'h01, {7'h00, d1[3]});
  endtask
  // Duty write only in manual mode, then spin-up reads zero
  task automatic t_manual();
    wc(a1, 8'h80);
    rc("duty1", a1, `FPD_DUTY_FULL);
    wc(a2, 8'h55);
    rc("duty2", a2, `FPD_DUTY_FULL);
    @(posedge clk) man <= 3'b001;
    wc(a1, 8'h80);
    rc("duty1", a1, 8'h80);
    chk("pwm0", 8'h80, pwm[0]);
    @(posedge clk) spin <= 3'b001;
    rc("spin", a1, `FPD_DUTY_ZERO);
    chk("pwm0", 8'h80, pwm[0]);
    @(posedge clk) spin <= 3'b000;
  endtask
  // Ready waits for power-up and converters
  task automatic t_ready();
    wt(150);
    chk("rdy", 8'h00, {7'h00, rdy});
    @(posedge clk) cok <= 1'b1;
    wt(3);
    chk("rdy", 8'h01, {7'h00, rdy});
  endtask
  // Start steers auto duty and limit choice
  task automatic t_start();
    wc(ct, 8'h01);
    wt(2);
    chk("upr", 8'h01, {7'h00, upr});
    rc("duty2", a2, 8'h40);
    rc("duty3", a3, 8'hC3);
    chk("pwm1", 8'h40, pwm[1]);
    chk("pwm0", 8'h80, pwm[0]);
    wc(ct, 8'h00);
    wt(1);
    chk("upr", 8'h00, {7'h00, upr});
  endtask
  // Lock is sticky, start stays writable, upper bits read zero
  task automatic t_lock();
    wc(ct, 8'h03);
    rc("ctrl", ct, 8'h07);
    chk("lck", 8'h01, {7'h00, lck});
    wc(ct, 8'h00);
    rc("ctrl", ct, 8'h06);
    wc(ct, 8'hF1);
    rc("ctrl", ct, 8'h07);
  endtask
  // Override beats disabled mode
  task automatic t_force();
    @(posedge clk) dis <= 3'b100;
    wt(2);
    chk("pwm2", `FPD_DUTY_ZERO, pwm[2]);
    wc(ct, 8'h09);
    rc("ctrl", ct, 8'h0F);
    chk("frc", 8'h01, {7'h00, frc});
    chk("pwm2", `FPD_DUTY_FULL, pwm[2]);
    chk("pwm0", `FPD_DUTY_FULL, pwm[0]);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_ident();
    t_manual();
    t_ready();
    t_start();
    t_lock();
    t_force();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule // tb
